//--- lbaa_pkg.sv
// Functional notes
// - Judge the input over fixed 128 ms periods; update the bucket once per period.
// - A period is faulty when the input failed or was erratic during it.
// - Each faulty period adds exactly one to the bucket.
// - Without fault, subtract one per leak interval of 1, 2, 4 or 8 periods, floor zero.
// - Leak field 00/01/10/11 selects 128/256/512/1024 ms; upper six bits unused.
// - Raise the alarm when the bucket reaches the upper threshold.
// - Clear the alarm when the bucket falls to the lower threshold.
// - Bucket saturates at the programmed size, 1 to 255; faults beyond are ignored.
package lbaa_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned LBAA_CLK_HZ = 125000000;
    localparam int unsigned LBAA_PERIOD_MS = 128;
    localparam int unsigned LBAA_PERIOD_CYCLES = LBAA_CLK_HZ / 1000 * LBAA_PERIOD_MS;

    // ----------------------------------------
    // Register byte addresses (printed index times four)
    // ----------------------------------------
    localparam logic [7:0] LBAA_IDX_LEAK = 8'h57;
    localparam logic [7:0] LBAA_IDX_CLEAR = 8'h59;
    localparam logic [7:0] LBAA_IDX_RAISE = 8'h58;
    localparam logic [7:0] LBAA_IDX_SIZE = 8'h5A;
    localparam logic [7:0] LBAA_IDX_STATUS = 8'h60;
    localparam logic [7:0] LBAA_IDX_MASK = 8'h61;
    localparam logic [7:0] LBAA_IDX_FILL = 8'h62;
    localparam logic [9:0] LBAA_ADDR_LEAK = {LBAA_IDX_LEAK, 2'b00};
    localparam logic [9:0] LBAA_ADDR_CLEAR = {LBAA_IDX_CLEAR, 2'b00};
    localparam logic [9:0] LBAA_ADDR_RAISE = {LBAA_IDX_RAISE, 2'b00};
    localparam logic [9:0] LBAA_ADDR_SIZE = {LBAA_IDX_SIZE, 2'b00};
    localparam logic [9:0] LBAA_ADDR_STATUS = {LBAA_IDX_STATUS, 2'b00};
    localparam logic [9:0] LBAA_ADDR_MASK = {LBAA_IDX_MASK, 2'b00};
    localparam logic [9:0] LBAA_ADDR_FILL = {LBAA_IDX_FILL, 2'b00};

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [1:0] LBAA_LEAK_RST = 2'h1;
    localparam logic [7:0] LBAA_CLEAR_RST = 8'h04;
    localparam logic [7:0] LBAA_RAISE_RST = 8'h06;
    localparam logic [7:0] LBAA_SIZE_RST = 8'h08;
    localparam logic [7:0] LBAA_SIZE_MIN = 8'h01;

    // ----------------------------------------
    // Status bit positions
    // ----------------------------------------
    localparam int unsigned LBAA_ST_RAISE = 0;
    localparam int unsigned LBAA_ST_CLEAR = 1;
    localparam int unsigned LBAA_ST_FAULT = 2;

endpackage

//--- lbaa_tick.sv
`timescale 1ns/100ps
// Divider that issues a one-cycle pulse at the end of every monitoring period.
module lbaa_tick
    import lbaa_pkg::*;
#(
    parameter int unsigned PERIOD_CYCLES = LBAA_PERIOD_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);

    typedef struct packed {
        logic [27:0] count;
        logic tick;
    } lbaa_tick_state_t;

    lbaa_tick_state_t state;
    lbaa_tick_state_t next_state;

    // Count cycles and pulse on the last one of each period.
    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        if (state.count == 28'(PERIOD_CYCLES - 1)) begin
            next_state.count = 28'h000_0000;
            next_state.tick = 1'b1;
        end else begin
            next_state.count = state.count + 28'h000_0001;
        end
    end

    // Register the divider state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick = state.tick;

endmodule

//--- lbaa_top.sv
`timescale 1ns/100ps
// Leaky-bucket activity alarm with an APB register slave.
module lbaa_top
    import lbaa_pkg::*;
#(
    parameter int unsigned PERIOD_CYCLES = LBAA_PERIOD_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic input_failed,
    input wire logic input_erratic,
    output logic alarm,
    output logic [7:0] fill,
    output logic irq
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] leak_rate_cfg_one;
        logic [7:0] alarm_clear_level_two;
        logic [7:0] alarm_raise_level_two;
        logic [7:0] bucket_size;
        logic [2:0] status;
        logic [2:0] mask;
        logic [7:0] bucket;
        logic alarm;
        logic fault_seen;
        logic [2:0] leak_count;
        logic [31:0] rdata;
        logic slverr;
    } lbaa_state_t;

    lbaa_state_t state;
    lbaa_state_t next_state;
    logic tick;

    // Number of periods per leak step, minus one.
    function automatic logic [2:0] lbaa_leak_last(input logic [1:0] rate);
        lbaa_leak_last = 3'((4'h1 << rate) - 4'h1);
    endfunction

    // Whether an address is a mapped register.
    function automatic logic lbaa_mapped(input logic [11:0] addr);
        lbaa_mapped = (addr[11:10] == 2'b00) && (addr[1:0] == 2'b00) &&
            (addr[9:0] == LBAA_ADDR_LEAK || addr[9:0] == LBAA_ADDR_CLEAR ||
             addr[9:0] == LBAA_ADDR_RAISE || addr[9:0] == LBAA_ADDR_SIZE ||
             addr[9:0] == LBAA_ADDR_STATUS || addr[9:0] == LBAA_ADDR_MASK ||
             addr[9:0] == LBAA_ADDR_FILL);
    endfunction

    // ----------------------------------------
    // Period divider
    // ----------------------------------------
    lbaa_tick #(
        .PERIOD_CYCLES(PERIOD_CYCLES)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    logic access;
    logic wr;
    logic [9:0] waddr;
    logic [2:0] ev;

    assign access = psel && penable;
    assign wr = access && pwrite && lbaa_mapped(paddr) && pstrb[0];
    assign waddr = paddr[9:0];

    // Next-state logic: bucket, alarm, events and register access.
    always_comb begin
        next_state = state;
        ev = 3'b000;

        // Any fault level seen during the period marks it faulty.
        if (input_failed || input_erratic) begin
            next_state.fault_seen = 1'b1;
        end

        if (tick) begin
            next_state.fault_seen = 1'b0; // The tick cycle belongs to the period that ends here.
            if (state.fault_seen || input_failed || input_erratic) begin
                ev[LBAA_ST_FAULT] = 1'b1;
                next_state.leak_count = 3'h0;
                if (state.bucket < state.bucket_size) begin
                    next_state.bucket = state.bucket + 8'h01;
                end
            end else if (state.leak_count >= lbaa_leak_last(state.leak_rate_cfg_one)) begin
                next_state.leak_count = 3'h0;
                if (state.bucket != 8'h00) begin
                    next_state.bucket = state.bucket - 8'h01;
                end
            end else begin
                next_state.leak_count = state.leak_count + 3'h1;
            end
        end

        // Hysteresis between the two levels; alarm holds in between.
        if (!state.alarm && next_state.bucket >= state.alarm_raise_level_two) begin
            next_state.alarm = 1'b1;
            ev[LBAA_ST_RAISE] = 1'b1;
        end else if (state.alarm && next_state.bucket <= state.alarm_clear_level_two) begin
            next_state.alarm = 1'b0;
            ev[LBAA_ST_CLEAR] = 1'b1;
        end

        // Register writes take effect at the access edge.
        if (wr) begin
            unique case (waddr)
                LBAA_ADDR_LEAK: next_state.leak_rate_cfg_one = pwdata[1:0];
                LBAA_ADDR_CLEAR: next_state.alarm_clear_level_two = pwdata[7:0];
                LBAA_ADDR_RAISE: next_state.alarm_raise_level_two = pwdata[7:0];
                LBAA_ADDR_SIZE: begin
                    // A zero size is held at the smallest legal value.
                    next_state.bucket_size = (pwdata[7:0] == 8'h00) ? LBAA_SIZE_MIN : pwdata[7:0];
                end
                LBAA_ADDR_STATUS: next_state.status = state.status & ~pwdata[2:0];
                LBAA_ADDR_MASK: next_state.mask = pwdata[2:0];
                default: next_state.status = state.status;
            endcase
        end
        // New events win over a clear in the same cycle.
        next_state.status = next_state.status | ev;

        // Read data are captured into a register at the setup cycle.
        next_state.slverr = 1'b0;
        if (psel && !penable) begin
            next_state.rdata = 32'h0000_0000;
            next_state.slverr = !lbaa_mapped(paddr);
            if (!pwrite && lbaa_mapped(paddr)) begin
                unique case (waddr)
                    LBAA_ADDR_LEAK: next_state.rdata = {30'h0000_0000, state.leak_rate_cfg_one};
                    LBAA_ADDR_CLEAR: next_state.rdata = {24'h00_0000, state.alarm_clear_level_two};
                    LBAA_ADDR_RAISE: next_state.rdata = {24'h00_0000, state.alarm_raise_level_two};
                    LBAA_ADDR_SIZE: next_state.rdata = {24'h00_0000, state.bucket_size};
                    LBAA_ADDR_STATUS: next_state.rdata = {29'h0000_0000, state.status};
                    LBAA_ADDR_MASK: next_state.rdata = {29'h0000_0000, state.mask};
                    default: next_state.rdata = {23'h00_0000, state.alarm, state.bucket};
                endcase
            end
        end else if (access) begin
            next_state.slverr = state.slverr;
        end
    end

    // Register all state; bucket and alarm start cleared.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state.leak_rate_cfg_one <= LBAA_LEAK_RST;
            state.alarm_clear_level_two <= LBAA_CLEAR_RST;
            state.alarm_raise_level_two <= LBAA_RAISE_RST;
            state.bucket_size <= LBAA_SIZE_RST;
            state.status <= 3'h0;
            state.mask <= 3'h0;
            state.bucket <= 8'h00;
            state.alarm <= 1'b0;
            state.fault_seen <= 1'b0;
            state.leak_count <= 3'h0;
            state.rdata <= 32'h0000_0000;
            state.slverr <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign pready = 1'b1;
    assign prdata = state.rdata;
    assign pslverr = access && state.slverr;
    assign alarm = state.alarm;
    assign fill = state.bucket;
    assign irq = |(state.status & state.mask);

endmodule

//--- lbaa_checker.sv
`timescale 1ns/100ps
// Checks the bucket count and alarm against shadowed levels.
module lbaa_checker
    import lbaa_pkg::*;
#(
    parameter int unsigned PERIOD_CYCLES = LBAA_PERIOD_CYCLES
) (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0] pstrb,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic input_failed,
    input logic input_erratic,
    input logic alarm,
    input logic [7:0] fill,
    input logic irq
);
    typedef struct packed {logic [7:0] hi; logic [7:0] lo; logic [7:0] sz; logic [31:0] qt;} lbaa_chk_t;
    lbaa_chk_t st;
    lbaa_chk_t next_st;
    logic wr;
    // Shadows the levels as writes land and counts cycles since the last fault.
    assign wr = psel && penable && pwrite && pready && pstrb[0];
    always_comb begin
        next_st = st;
        if (wr && paddr == {2'b00, LBAA_ADDR_RAISE}) begin
            next_st.hi = pwdata[7:0];
        end
        if (wr && paddr == {2'b00, LBAA_ADDR_CLEAR}) begin
            next_st.lo = pwdata[7:0];
        end
        if (wr && paddr == {2'b00, LBAA_ADDR_SIZE}) begin
            next_st.sz = (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
        end
        next_st.qt = (input_failed || input_erratic) ? 32'h0000_0000 : st.qt + 32'h0000_0001;
    end
    // Registers the shadow state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= {LBAA_RAISE_RST, LBAA_CLEAR_RST, LBAA_SIZE_RST, 32'h0000_0000};
        end else begin
            st <= next_st;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    fill_step_a: assert property ($changed(fill) |-> fill == $past(fill) + 8'h01 || fill == $past(fill) - 8'h01)
        else $error("fill jumped");
    fill_hold_a: assert property ($changed(fill) |=> $stable(fill) [*8])
        else $error("fill moved twice in a period");
    fill_max_a: assert property (fill <= st.sz)
        else $error("fill above size");
    fill_up_a: assert property (fill > $past(fill) |-> st.qt <= PERIOD_CYCLES + 2)
        else $error("rise without fault");
    fill_down_a: assert property (fill < $past(fill) |-> st.qt >= PERIOD_CYCLES - 1)
        else $error("leak after fault");
    alarm_raise_a: assert property (st.hi > st.lo && fill >= st.hi |-> ##[0:2] alarm)
        else $error("alarm not raised");
    alarm_clear_a: assert property (st.hi > st.lo && fill <= st.lo |-> ##[0:2] !alarm)
        else $error("alarm not cleared");
    alarm_keep_a: assert property (fill > st.lo && fill < st.hi && $stable(fill) |-> $stable(alarm))
        else $error("alarm moved in band");
    reset_clear_a: assert property ($rose(presetn) |-> fill == 8'h00 && !alarm)
        else $error("not cleared by reset");
    cover property (fill == st.sz);
    cover property ($rose(alarm));
    cover property ($fell(alarm));
endmodule
bind lbaa_top lbaa_checker #(.PERIOD_CYCLES(PERIOD_CYCLES)) u_chk (.*);

//--- lbaa_ref_model.sv
`timescale 1ns/100ps
// Watched reference: clean, dead, or glitching.
module lbaa_ref_model (
    input logic pclk,
    input logic [1:0] mode,
    output logic input_failed = 1'b0,
    output logic input_erratic = 1'b0
);
    logic [2:0] ph = 3'h0;
    // Mode 1 holds the failure flag; mode 2 glitches one cycle in eight.
    always @(posedge pclk) begin
        ph <= ph + 3'h1;
        input_failed <= (mode == 2'h1);
        input_erratic <= (mode == 2'h2) && (ph == 3'h0);
    end
endmodule

//--- tb_top.sv
`timescale 1ns/100ps
// Self-checking bench for the leaky-bucket alarm.
module tb_top;
    import lbaa_pkg::*;
    localparam int unsigned PER = 20;
    typedef struct {logic w; logic [9:0] a; logic [7:0] d; logic [7:0] x;} lbaa_row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, input_failed, input_erratic, alarm, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [7:0] fill;
    logic [1:0] mode;
    int bad_count = 0;
    int tests_run = 0;
    int n;
    lbaa_row_t rows [9] = '{'{1'b0, LBAA_ADDR_LEAK, 8'h00, 8'h01}, '{1'b0, LBAA_ADDR_CLEAR, 8'h00, 8'h04},
        '{1'b0, LBAA_ADDR_RAISE, 8'h00, 8'h06}, '{1'b0, LBAA_ADDR_SIZE, 8'h00, 8'h08},
        '{1'b0, LBAA_ADDR_MASK, 8'h00, 8'h00}, '{1'b1, LBAA_ADDR_LEAK, 8'hff, 8'h03},
        '{1'b1, LBAA_ADDR_SIZE, 8'h00, 8'h01}, '{1'b1, LBAA_ADDR_SIZE, 8'h08, 8'h08},
        '{1'b1, LBAA_ADDR_MASK, 8'h01, 8'h01}};
    lbaa_top #(.PERIOD_CYCLES(PER)) u_dut (.*);
    lbaa_ref_model u_ref (.*);
    // Prints the verdict and stops.
    task automatic end_of_test();
        if (bad_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; holds the request until pready is seen high.
    task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, a};
        pwdata <= 32'(d);
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            bad_count++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Waits for the count to move and returns the cycles taken; samples at the falling edge.
    task automatic wfill(output int c);
        logic [7:0] f0;
        f0 = fill;
        c = 0;
        do begin
            @(negedge pclk);
            c++;
        end while (fill === f0 && c < 1000);
        if (c >= 1000) begin
            bad_count++;
            end_of_test();
        end
    endtask
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Main sequence.
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, mode} = '0;
        pstrb = 4'hf;
        repeat (2) @(posedge pclk);
        chk(32'({alarm, irq, fill}), 32'h0000_0000);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) begin
                apb(1'b1, rows[i].a, rows[i].d);
            end
            apb(1'b0, rows[i].a, 8'h00);
            chk(rd, 32'(rows[i].x));
        end
        apb(1'b0, 10'h004, 8'h00);
        chk(32'({rd, err}), 32'h0000_0001);
        pstrb <= 4'h0;
        apb(1'b1, LBAA_ADDR_MASK, 8'h00);
        pstrb <= 4'hf;
        apb(1'b0, LBAA_ADDR_MASK, 8'h00);
        chk(rd, 32'h0000_0001);
        mode <= 2'h1;
        wfill(n);
        chk(32'({irq, fill}), 32'h0000_0001);
        repeat (7) wfill(n);
        chk(32'({alarm, irq, fill}), 32'h0000_0308);
        repeat (3 * PER) @(posedge pclk);
        chk(32'(fill), 32'h0000_0008);
        mode <= 2'h0;
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, LBAA_ADDR_LEAK, 8'(c));
            wfill(n);
            wfill(n);
            chk(32'(n), 32'(PER << c));
        end
        chk(32'({alarm, fill}), 32'h0000_0000);
        repeat (10 * PER) @(posedge pclk);
        chk(32'(fill), 32'h0000_0000);
        apb(1'b0, LBAA_ADDR_STATUS, 8'h00);
        chk(32'({irq, rd[7:0]}), 32'h0000_0107);
        apb(1'b1, LBAA_ADDR_STATUS, 8'h07);
        apb(1'b0, LBAA_ADDR_STATUS, 8'h00);
        chk(32'({irq, rd[7:0]}), 32'h0000_0000);
        mode <= 2'h2;
        wfill(n);
        chk(32'(fill), 32'h0000_0001);
        presetn <= 1'b0;
        @(posedge pclk);
        chk(32'(fill), 32'h0000_0000);
        presetn <= 1'b1;
        repeat (2) @(negedge pclk);
        chk(32'({alarm, irq, fill}), 32'h0000_0000);
        apb(1'b0, LBAA_ADDR_LEAK, 8'h00);
        chk(rd, 32'(LBAA_LEAK_RST));
        end_of_test();
    end
endmodule
